// >>> logic/rssap_pkg.sv
package rssap_pkg;
    // ==========================================================
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int CONV_TIME_US = 115;
    localparam int CONV_CYCLES = (CONV_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam int INIT_CYCLES = 16;
    localparam int CNT_W = 14;
    // ==========================================================
    // widths and frame counts
    localparam int CODE_W = 11;
    localparam int CMD_W = 8;
    localparam int ANS_W = 16;
    localparam logic [4:0] CMD_LAST_CLK = 5'h07;
    localparam logic [4:0] FRAME_LAST_CLK = 5'h17;
    localparam logic [4:0] ANS_BITS = 5'h10;
    // ==========================================================
    // opcodes
    localparam logic [7:0] OP_STATUS = 8'h88;
    localparam logic [7:0] OP_RESULT = 8'h80;
    localparam logic [3:0] OP_CTRL_HI = 4'h9;
    localparam logic [1:0] OP_CTRL_LO = 2'h0;
    localparam int CMD_CHANNEL_SELECT_BIT = 3;
    localparam int CMD_EN_BIT = 2;
    // ==========================================================
    // answer fields
    localparam int ANS_REFUSE_BIT = 15;
    localparam int ANS_OPC_BIT = 14;
    localparam int ANS_EOC_BIT = 13;
    localparam int ANS_BUSY_BIT = 10;
    localparam int ANS_CHANNEL_SELECT_BIT = 3;
    localparam int ANS_EN_BIT = 2;
    localparam int ANS_CODE_LSB = 1;
    // ==========================================================
    // values after reset
    localparam logic EN_RST = 1'b0;
    localparam logic CHANNEL_SELECT_RST = 1'b0;
    localparam logic EOC_RST = 1'b1;
    localparam logic BUSY_RST = 1'b1;
    localparam logic [10:0] CODE_RST = 11'h000;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CMD = 2'b01,
        ST_ANS = 2'b11,
        ST_DONE = 2'b10
    } rssap_state_t;
endpackage

// >>> logic/rssap_adc_if.sv
`timescale 1ns/1ps
interface rssap_adc_if;
    logic write;
    logic start;
    logic channel_select_req;
    logic en_req;
    logic enable;
    logic channel;
    logic eoc;
    logic [10:0] code;
    modport ctrl (output write, start, channel_select_req, en_req, input enable, channel, eoc, code);
    modport conv (input write, start, channel_select_req, en_req, output enable, channel, eoc, code);
endinterface

// >>> logic/rssap_conv.sv
`timescale 1ns/1ps
module rssap_conv #(
    parameter int CONV_CYCLES = rssap_pkg::CONV_CYCLES
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    // sar core result
    input wire logic [10:0] sar_code_in,
    // control side
    rssap_adc_if.conv adc
);
    localparam logic [rssap_pkg::CNT_W-1:0] CONV_LOAD = rssap_pkg::CNT_W'(CONV_CYCLES - 1);

    logic enable_reg;
    logic channel_reg;
    logic eoc_reg;
    logic [10:0] code_reg;
    logic [rssap_pkg::CNT_W-1:0] cnt_reg;

    // ==========================================================
    // power and channel latch
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            enable_reg <= rssap_pkg::EN_RST;
            channel_reg <= rssap_pkg::CHANNEL_SELECT_RST;
        end else if (ce_in && adc.write) begin
            enable_reg <= adc.en_req;
            channel_reg <= adc.channel_select_req;
        end
    end

    // ==========================================================
    // conversion timer
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            eoc_reg <= rssap_pkg::EOC_RST;
            cnt_reg <= '0;
            code_reg <= rssap_pkg::CODE_RST;
        end else if (ce_in) begin
            if (adc.start) begin
                eoc_reg <= 1'b0;
                cnt_reg <= CONV_LOAD;
            end else if (!eoc_reg) begin
                if (cnt_reg == '0) begin
                    eoc_reg <= 1'b1;
                    code_reg <= sar_code_in;
                end else begin
                    cnt_reg <= cnt_reg - 1'b1;
                end
            end
        end
    end

    assign adc.enable = enable_reg;
    assign adc.channel = channel_reg;
    assign adc.eoc = eoc_reg;
    assign adc.code = code_reg;

    AST_EOC_FALLS: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (ce_in && adc.start) |=> !adc.eoc)
        else $error("conversion start did not clear end of conversion");
    AST_EN_ONLY_BY_CTRL: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (ce_in && !adc.write) |=> ($stable(adc.enable) && $stable(adc.channel)))
        else $error("enable or channel changed without control instruction");
endmodule

// >>> logic/rssap_top.sv
`timescale 1ns/1ps
// How it works
// - slave only, clock is input, miso output
// - deselected: ignore mosi, miso released
// - deselect returns interface to idle start
// - eight bit instructions, sixteen bit answers
// - all words shifted most significant first
// - mosi sampled on sclk rising into byte
// - execute after eighth bit, always answer
// - full frame lasts twenty four clocks
// - unknown opcode rejected with refusal answer
// - unknown opcode flag set in refusal
// - partial instruction discarded on deselect
// - deselect truncates answer mid shift
// - eleven bit result, rate or temperature
// - after reset converter asleep, channel zero
// - control instruction powers, selects, starts
// - enable zero sleeps, one allows conversion
// - channel zero rate, one temperature
// - eoc low while running, start refused
// - busy after reset refuses every instruction
// - progress via status or result read
// - refusal: bit15, opc14, eoc13, busy10
// - control opcode 1001, channel_select, enable, 00
// - status answer: eoc13, chan3, enable2
// - result answer: code bits 11..1, eoc13
module rssap_top #(
    parameter int CONV_CYCLES = rssap_pkg::CONV_CYCLES,
    parameter int INIT_CYCLES = rssap_pkg::INIT_CYCLES
) (
    // clock, reset, enable
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    input wire logic clk_en_in,
    // serial pins
    input wire logic sclk_in,
    input wire logic mosi_in,
    input wire logic ss_n_in,
    output logic miso_out,
    output logic miso_oe_out,
    // converter core
    input wire logic [10:0] sar_code_in,
    output logic adc_enable_out,
    output logic adc_channel_out,
    output logic adc_sampling_out,
    output logic init_busy_out
);
    localparam logic [rssap_pkg::CNT_W-1:0] INIT_LOAD = rssap_pkg::CNT_W'(INIT_CYCLES);

    // ==========================================================
    // answer helpers
    function automatic logic [15:0] refusal_word(input logic unknown_opcode_flag, input logic eoc,
                                                 input logic busy);
        logic [15:0] w;
        w = '0;
        w[rssap_pkg::ANS_REFUSE_BIT] = 1'b1;
        w[rssap_pkg::ANS_OPC_BIT] = unknown_opcode_flag;
        w[rssap_pkg::ANS_EOC_BIT] = eoc;
        w[rssap_pkg::ANS_BUSY_BIT] = busy;
        return w;
    endfunction

    function automatic logic is_ctrl(input logic [7:0] op);
        return (op[7:4] == rssap_pkg::OP_CTRL_HI) && (op[1:0] == rssap_pkg::OP_CTRL_LO);
    endfunction

    function automatic logic is_known(input logic [7:0] op);
        return is_ctrl(op) || (op == rssap_pkg::OP_STATUS) || (op == rssap_pkg::OP_RESULT);
    endfunction

    // ==========================================================
    // reset release
    logic rst_meta_reg;
    logic rst_n;
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rst_meta_reg <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n <= rst_meta_reg;
        end
    end

    // ==========================================================
    // pin synchronisers
    logic sclk_q1_reg, sclk_q2_reg, sclk_q3_reg;
    logic mosi_q1_reg, mosi_q2_reg;
    logic ss_q1_reg, ss_q2_reg;
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            sclk_q1_reg <= 1'b0;
            sclk_q2_reg <= 1'b0;
            sclk_q3_reg <= 1'b0;
            mosi_q1_reg <= 1'b0;
            mosi_q2_reg <= 1'b0;
            ss_q1_reg <= 1'b1;
            ss_q2_reg <= 1'b1;
        end else if (clk_en_in) begin
            sclk_q1_reg <= sclk_in;
            sclk_q2_reg <= sclk_q1_reg;
            sclk_q3_reg <= sclk_q2_reg;
            mosi_q1_reg <= mosi_in;
            mosi_q2_reg <= mosi_q1_reg;
            ss_q1_reg <= ss_n_in;
            ss_q2_reg <= ss_q1_reg;
        end
    end

    logic sclk_rise;
    logic sclk_fall;
    logic ss_sel;
    assign sclk_rise = sclk_q2_reg && !sclk_q3_reg;
    assign sclk_fall = !sclk_q2_reg && sclk_q3_reg;
    assign ss_sel = !ss_q2_reg;

    // ==========================================================
    // initialisation busy
    logic busy_reg;
    logic [rssap_pkg::CNT_W-1:0] init_cnt_reg;
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            busy_reg <= rssap_pkg::BUSY_RST;
            init_cnt_reg <= '0;
        end else if (clk_en_in && busy_reg) begin
            if (init_cnt_reg == INIT_LOAD) begin
                busy_reg <= 1'b0;
            end else begin
                init_cnt_reg <= init_cnt_reg + 1'b1;
            end
        end
    end

    // ==========================================================
    // converter
    rssap_adc_if adc ();

    rssap_conv #(
        .CONV_CYCLES(CONV_CYCLES)
    ) u_conv (
        .clk_in(ref_clk_in),
        .rst_n_in(rst_n),
        .ce_in(clk_en_in),
        .sar_code_in(sar_code_in),
        .adc(adc)
    );

    // ==========================================================
    // frame state
    rssap_pkg::rssap_state_t state_reg;
    logic [4:0] clk_cnt_reg;
    logic [4:0] out_cnt_reg;
    logic [6:0] cmd_sh_reg;
    logic [15:0] ans_sh_reg;
    logic [15:0] ans_next;
    logic [7:0] cmd_next;
    logic exec;
    logic accept_ctrl;

    assign cmd_next = {cmd_sh_reg, mosi_q2_reg};
    assign exec = (state_reg == rssap_pkg::ST_CMD) && ss_sel && sclk_rise
                  && (clk_cnt_reg == rssap_pkg::CMD_LAST_CLK);

    // ==========================================================
    // instruction decode and answer
    always_comb begin
        ans_next = '0;
        accept_ctrl = 1'b0;
        if (busy_reg) begin
            ans_next = refusal_word(1'b0, adc.eoc, busy_reg);
        end else if (!is_known(cmd_next)) begin
            ans_next = refusal_word(1'b1, adc.eoc, busy_reg);
        end else if (cmd_next == rssap_pkg::OP_RESULT) begin
            ans_next[rssap_pkg::ANS_EOC_BIT] = adc.eoc;
            ans_next[rssap_pkg::ANS_CODE_LSB +: rssap_pkg::CODE_W] = adc.code;
        end else if (cmd_next == rssap_pkg::OP_STATUS) begin
            ans_next[rssap_pkg::ANS_EOC_BIT] = adc.eoc;
            ans_next[rssap_pkg::ANS_CHANNEL_SELECT_BIT] = adc.channel;
            ans_next[rssap_pkg::ANS_EN_BIT] = adc.enable;
        end else if (!adc.eoc) begin
            ans_next = refusal_word(1'b0, adc.eoc, busy_reg);
        end else begin
            accept_ctrl = 1'b1;
            ans_next[rssap_pkg::ANS_EOC_BIT] = !cmd_next[rssap_pkg::CMD_EN_BIT];
            ans_next[rssap_pkg::ANS_CHANNEL_SELECT_BIT] = cmd_next[rssap_pkg::CMD_CHANNEL_SELECT_BIT];
            ans_next[rssap_pkg::ANS_EN_BIT] = cmd_next[rssap_pkg::CMD_EN_BIT];
        end
    end

    assign adc.write = exec && accept_ctrl;
    assign adc.start = exec && accept_ctrl && cmd_next[rssap_pkg::CMD_EN_BIT];
    assign adc.channel_select_req = cmd_next[rssap_pkg::CMD_CHANNEL_SELECT_BIT];
    assign adc.en_req = cmd_next[rssap_pkg::CMD_EN_BIT];

    // ==========================================================
    // frame sequencing
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= rssap_pkg::ST_IDLE;
            clk_cnt_reg <= '0;
        end else if (clk_en_in) begin
            if (!ss_sel) begin
                state_reg <= rssap_pkg::ST_IDLE;
                clk_cnt_reg <= '0;
            end else begin
                case (state_reg)
                    rssap_pkg::ST_IDLE: begin
                        state_reg <= rssap_pkg::ST_CMD;
                    end
                    rssap_pkg::ST_CMD: begin
                        if (sclk_rise) begin
                            clk_cnt_reg <= clk_cnt_reg + 1'b1;
                            if (exec) begin
                                state_reg <= rssap_pkg::ST_ANS;
                            end
                        end
                    end
                    rssap_pkg::ST_ANS: begin
                        if (sclk_rise) begin
                            clk_cnt_reg <= clk_cnt_reg + 1'b1;
                            if (clk_cnt_reg == rssap_pkg::FRAME_LAST_CLK) begin
                                state_reg <= rssap_pkg::ST_DONE;
                            end
                        end
                    end
                    rssap_pkg::ST_DONE: begin
                        state_reg <= rssap_pkg::ST_DONE;
                    end
                    default: begin
                        state_reg <= rssap_pkg::ST_IDLE;
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // instruction shift register
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            cmd_sh_reg <= '0;
        end else if (clk_en_in) begin
            if (!ss_sel) begin
                cmd_sh_reg <= '0;
            end else if (sclk_rise && state_reg == rssap_pkg::ST_CMD) begin
                cmd_sh_reg <= cmd_next[6:0];
            end
        end
    end

    // ==========================================================
    // answer shifter and output pin
    logic miso_reg;
    logic miso_oe_reg;
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            ans_sh_reg <= '0;
            out_cnt_reg <= '0;
            miso_reg <= 1'b0;
            miso_oe_reg <= 1'b0;
        end else if (clk_en_in) begin
            miso_oe_reg <= ss_sel;
            if (!ss_sel) begin
                out_cnt_reg <= '0;
                miso_reg <= 1'b0;
            end else if (exec) begin
                ans_sh_reg <= ans_next;
                out_cnt_reg <= '0;
            end else if (state_reg == rssap_pkg::ST_ANS && sclk_fall
                         && out_cnt_reg != rssap_pkg::ANS_BITS) begin
                miso_reg <= ans_sh_reg[15];
                ans_sh_reg <= {ans_sh_reg[14:0], 1'b0};
                out_cnt_reg <= out_cnt_reg + 1'b1;
            end else if (state_reg == rssap_pkg::ST_DONE) begin
                miso_reg <= 1'b0;
            end
        end
    end

    assign miso_out = miso_reg;
    assign miso_oe_out = miso_oe_reg;
    assign adc_enable_out = adc.enable;
    assign adc_channel_out = adc.channel;
    assign adc_sampling_out = !adc.eoc;
    assign init_busy_out = busy_reg;

    // ==========================================================
    // checks
    AST_MISO_HIZ: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
        (clk_en_in && ss_q2_reg) |=> !miso_oe_out)
        else $error("miso driven while deselected");
    AST_SS_RESTART: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
        (clk_en_in && ss_q2_reg) |=> (state_reg == rssap_pkg::ST_IDLE && clk_cnt_reg == 5'h00))
        else $error("deselect did not restart the interface");
    AST_EXEC_ON_EIGHTH: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
        adc.write |-> (clk_cnt_reg == rssap_pkg::CMD_LAST_CLK && sclk_rise && ss_sel))
        else $error("command executed outside the eighth clock");
    AST_BUSY_REFUSE: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
        (clk_en_in && exec && busy_reg) |=> (ans_sh_reg[15] && ans_sh_reg[10]))
        else $error("busy device gave a non refusal answer");
    AST_UNKNOWN: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
        (clk_en_in && exec && !busy_reg && !is_known(cmd_next))
        |-> !adc.write ##1 (ans_sh_reg[15:14] == 2'b11))
        else $error("unknown opcode not refused with flag");
    AST_CTRL_REFUSED: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
        (clk_en_in && exec && !busy_reg && is_ctrl(cmd_next) && !adc.eoc)
        |-> !adc.start ##1 (ans_sh_reg[15] && $stable(adc.enable) && $stable(adc.channel)))
        else $error("control accepted during conversion");
    AST_RESULT: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
        (clk_en_in && exec && !busy_reg && cmd_next == rssap_pkg::OP_RESULT)
        |=> (!ans_sh_reg[15] && ans_sh_reg[11:1] == $past(adc.code)))
        else $error("result answer lacks conversion code");
    AST_MSB_FIRST: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
        (clk_en_in && ss_sel && state_reg == rssap_pkg::ST_ANS && sclk_fall
         && out_cnt_reg == 5'h00) |=> (miso_out == $past(ans_sh_reg[15])))
        else $error("answer msb not driven first after falling edge");
    AST_FRAME_END: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
        (clk_en_in && ss_sel && sclk_rise && state_reg == rssap_pkg::ST_ANS
         && clk_cnt_reg == rssap_pkg::FRAME_LAST_CLK) |=> (state_reg == rssap_pkg::ST_DONE))
        else $error("frame did not end after twenty four clocks");
    AST_CMD_CLEARED: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
        (clk_en_in && ss_q2_reg) |=> (cmd_sh_reg == 7'h00))
        else $error("partial instruction kept after deselect");
    AST_TRUNCATE: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
        (clk_en_in && ss_q2_reg && state_reg == rssap_pkg::ST_ANS)
        |=> (out_cnt_reg == 5'h00 && !miso_out))
        else $error("answer kept shifting after deselect");
    AST_DONE_QUIET: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
        (clk_en_in && ss_sel && state_reg == rssap_pkg::ST_DONE) |=> !miso_out)
        else $error("miso active after the twenty fourth clock");
    AST_ACCEPT_MSB_CLEAR: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
        (clk_en_in && exec && !busy_reg && is_known(cmd_next)
         && !(is_ctrl(cmd_next) && !adc.eoc)) |=> !ans_sh_reg[rssap_pkg::ANS_REFUSE_BIT])
        else $error("accepted instruction answered with refusal bit");
    AST_STATUS_FIELDS: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
        (clk_en_in && exec && !busy_reg && cmd_next == rssap_pkg::OP_STATUS)
        |=> (ans_sh_reg[rssap_pkg::ANS_EOC_BIT] == $past(adc.eoc)
             && ans_sh_reg[rssap_pkg::ANS_CHANNEL_SELECT_BIT] == $past(adc.channel)
             && ans_sh_reg[rssap_pkg::ANS_EN_BIT] == $past(adc.enable)))
        else $error("status answer fields wrong");
    AST_CTRL_APPLY: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
        (clk_en_in && adc.write) |=> (adc.enable == $past(adc.en_req)
                                      && adc.channel == $past(adc.channel_select_req)))
        else $error("control instruction not applied");
endmodule

// >>> verification/rssap_master_model.sv
`timescale 1ns/1ps
// ==========================================================
// serial master: mode 0, sclk parked low outside frames
module rssap_master_model (
    // clock
    input wire logic clk_in,
    // serial pins
    output logic sclk_out,
    output logic mosi_out,
    output logic ss_n_out,
    input wire logic miso_in
);
    localparam int HALF_CYC = 8;

    initial begin
        sclk_out = 1'b0;
        mosi_out = 1'b0;
        ss_n_out = 1'b1;
    end

    // ==========================================================
    // one frame; nclk below 24 ends it early, answer bits gather lsb-aligned
    task automatic xfer(input logic [7:0] cmd, input int nclk, output logic [15:0] ans);
        ans = 16'h0000;
        ss_n_out <= 1'b0;
        repeat (4) @(posedge clk_in);
        for (int i = 0; i < nclk; i++) begin
            // data past the instruction is filler that changes every clock
            mosi_out <= (i < 8) ? cmd[7 - i] : ~mosi_out;
            repeat (HALF_CYC) @(posedge clk_in);
            sclk_out <= 1'b1;
            if (i >= 8) begin
                ans = {ans[14:0], miso_in};
            end
            repeat (HALF_CYC) @(posedge clk_in);
            sclk_out <= 1'b0;
        end
        repeat (4) @(posedge clk_in);
        ss_n_out <= 1'b1;
        mosi_out <= ~mosi_out;
        repeat (6) @(posedge clk_in);
    endtask
endmodule

// >>> verification/test_rate_sensor_spi_adc_port.sv
`timescale 1ns/1ps
`define RSSAP_CHECK(what, exp, got) \
    compares++; \
    if ((got) !== (exp)) begin \
        fails++; \
        $display("mismatch %s expected %h seen %h", what, exp, got); \
    end

module test_rate_sensor_spi_adc_port;
    localparam int CONV_SIM = 1000;
    localparam int INIT_SIM = 200;
    localparam int LIMIT = 20000;
    typedef struct packed {
        logic [7:0] cmd;
        logic [10:0] sar;
        logic [15:0] ans;
        logic en;
        logic ch;
    } rssap_row_t;
    logic clk;
    logic rstn;
    logic clk_en;
    logic sclk;
    logic mosi;
    logic ss_n;
    logic miso;
    logic miso_oe;
    logic [10:0] sar;
    logic adc_en;
    logic adc_ch;
    logic adc_samp;
    logic busy;
    wire logic miso_wire;
    logic [15:0] ans;
    int fails = 0;
    int compares = 0;
    int cycles = 0;
    // ==========================================================
    // rows: opcode, converter result, answer, enable and channel after
    rssap_row_t rows [0:13] = '{
        {8'h88, 11'h5a3, 16'h2000, 1'b0, 1'b0},
        {8'h55, 11'h5a3, 16'he000, 1'b0, 1'b0},
        {8'h90, 11'h5a3, 16'h2000, 1'b0, 1'b0},
        {8'h9c, 11'h5a3, 16'h000c, 1'b1, 1'b1},
        {8'h88, 11'h5a3, 16'h000c, 1'b1, 1'b1},
        {8'h98, 11'h5a3, 16'h8000, 1'b1, 1'b1},
        {8'h80, 11'h5a3, 16'h2b46, 1'b1, 1'b1},
        {8'h88, 11'h5a3, 16'h200c, 1'b1, 1'b1},
        {8'h95, 11'h5a3, 16'he000, 1'b1, 1'b1},
        {8'h94, 11'h2b1, 16'h0004, 1'b1, 1'b0},
        {8'h00, 11'h2b1, 16'hc000, 1'b1, 1'b0},
        {8'h80, 11'h2b1, 16'h0b46, 1'b1, 1'b0},
        {8'h80, 11'h2b1, 16'h2562, 1'b1, 1'b0},
        {8'h90, 11'h2b1, 16'h2000, 1'b0, 1'b0}
    };

    // miso has no pull: floats whenever the device releases it
    assign miso_wire = miso_oe ? miso : 1'bz;

    rssap_top #(
        .CONV_CYCLES(CONV_SIM),
        .INIT_CYCLES(INIT_SIM)
    ) dut (
        .ref_clk_in(clk),
        .rstn_in(rstn),
        .clk_en_in(clk_en),
        .sclk_in(sclk),
        .mosi_in(mosi),
        .ss_n_in(ss_n),
        .miso_out(miso),
        .miso_oe_out(miso_oe),
        .sar_code_in(sar),
        .adc_enable_out(adc_en),
        .adc_channel_out(adc_ch),
        .adc_sampling_out(adc_samp),
        .init_busy_out(busy)
    );

    rssap_master_model master (
        .clk_in(clk),
        .sclk_out(sclk),
        .mosi_out(mosi),
        .ss_n_out(ss_n),
        .miso_in(miso_wire)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ==========================================================
    // closing report
    task automatic complete_run();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic wait_ready();
        for (int k = 0; k < 1000 && busy !== 1'b0; k++) begin
            @(posedge clk);
        end
        `RSSAP_CHECK("busy", 1'b0, busy)
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            fails++;
            complete_run();
        end
    end

    initial begin
        rstn = 1'b0;
        clk_en = 1'b1;
        sar = 11'h000;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        wait_ready();
        for (int i = 0; i < 14; i++) begin
            sar <= rows[i].sar;
            master.xfer(rows[i].cmd, 24, ans);
            `RSSAP_CHECK("answer", rows[i].ans, ans)
            `RSSAP_CHECK("enable", rows[i].en, adc_en)
            `RSSAP_CHECK("channel", rows[i].ch, adc_ch)
            `RSSAP_CHECK("miso_oe", 1'b0, miso_oe)
            $display("row %0d done", i);
        end
        // cut answer short after its upper byte
        master.xfer(8'h88, 16, ans);
        `RSSAP_CHECK("upper byte", 16'h0020, ans)
        `RSSAP_CHECK("miso_oe idle", 1'b0, miso_oe)
        // instruction cut after five bits must leave no trace
        master.xfer(8'h9c, 5, ans);
        `RSSAP_CHECK("enable kept", 1'b0, adc_en)
        master.xfer(8'h88, 24, ans);
        `RSSAP_CHECK("status after cut", 16'h2000, ans)
        $display("framing test done");
        // reset while a conversion is running
        master.xfer(8'h9c, 24, ans);
        `RSSAP_CHECK("sampling", 1'b1, adc_samp)
        rstn <= 1'b0;
        repeat (3) @(posedge clk);
        `RSSAP_CHECK("reset enable", 1'b0, adc_en)
        `RSSAP_CHECK("reset channel", 1'b0, adc_ch)
        `RSSAP_CHECK("reset sampling", 1'b0, adc_samp)
        `RSSAP_CHECK("reset busy", 1'b1, busy)
        `RSSAP_CHECK("reset miso_oe", 1'b0, miso_oe)
        rstn <= 1'b1;
        // clock enable low freezes the init counter past its normal end
        clk_en <= 1'b0;
        repeat (300) @(posedge clk);
        `RSSAP_CHECK("frozen busy", 1'b1, busy)
        clk_en <= 1'b1;
        master.xfer(8'h88, 24, ans);
        `RSSAP_CHECK("busy refusal", 16'ha400, ans)
        wait_ready();
        master.xfer(8'h88, 24, ans);
        `RSSAP_CHECK("status after init", 16'h2000, ans)
        $display("reset test done");
        complete_run();
    end
endmodule
